/* src/cvo_pkg.sv */
package cvo_pkg;
  // Direct register addresses
  localparam logic [4:0] CVO_ADDR_PAT_WADDR  = 5'h02;
  localparam logic [4:0] CVO_ADDR_PAT_RADDR  = 5'h03;
  localparam logic [4:0] CVO_ADDR_CCOL_DATA  = 5'h05;
  localparam logic [4:0] CVO_ADDR_CCOL_WADDR = 5'h06;
  localparam logic [4:0] CVO_ADDR_CCOL_RADDR = 5'h07;
  localparam logic [4:0] CVO_ADDR_SETUP      = 5'h09;
  localparam logic [4:0] CVO_ADDR_STATUS     = 5'h0a;
  localparam logic [4:0] CVO_ADDR_PAT_DATA   = 5'h0b;
  localparam logic [4:0] CVO_ADDR_CX_LO      = 5'h0c;
  localparam logic [4:0] CVO_ADDR_CX_HI      = 5'h0d;
  localparam logic [4:0] CVO_ADDR_CY_LO      = 5'h0e;
  localparam logic [4:0] CVO_ADDR_CY_HI      = 5'h0f;
  localparam logic [4:0] CVO_ADDR_VFMT       = 5'h10;
  localparam logic [4:0] CVO_ADDR_OVL        = 5'h11;
  localparam logic [4:0] CVO_ADDR_GAM_WADDR  = 5'h14;
  localparam logic [4:0] CVO_ADDR_GAM_DATA   = 5'h15;
  localparam logic [4:0] CVO_ADDR_GAM_RADDR  = 5'h17;

  // Field positions
  localparam int CVO_SETUP_CLKSEL  = 4;
  localparam int CVO_SETUP_SCAN    = 3;
  localparam int CVO_SETUP_PMAP    = 2;
  localparam int CVO_VFMT_EXTPAL   = 7;
  localparam int CVO_VFMT_GCLKSEL  = 6;
  localparam int CVO_VFMT_DOUBLE   = 5;
  localparam int CVO_VFMT_GAMMA_BYPASS     = 4;
  localparam int CVO_VSD_TAG_MSB5  = 15;
  localparam int CVO_VSD_TAG_MSB8  = 31;
  localparam int CVO_VSD_TAG_UV    = 0;

  // Reset values, last colour pointer and software key zone code
  localparam logic [7:0] CVO_RST_BYTE   = 8'h00;
  localparam logic [1:0] CVO_PTR_RED    = 2'h0;
  localparam logic [1:0] CVO_PTR_BLUE   = 2'h2;
  localparam logic [3:0] CVO_ZONE_SOFTWARE_KEY_SELECT = 4'hc;

  typedef enum logic [1:0] {
    CVO_CUR_OFF   = 2'b00,
    CVO_CUR_THREE = 2'b01,
    CVO_CUR_HILITE = 2'b10,
    CVO_CUR_TWO   = 2'b11
  } cvo_cursor_e;

  typedef enum logic [3:0] {
    CVO_FMT_YUV     = 4'b0000,
    CVO_FMT_YUV_TAG = 4'b0001,
    CVO_FMT_RGB565  = 4'b1000,
    CVO_FMT_RGB555  = 4'b1010,
    CVO_FMT_TRGB555 = 4'b1011,
    CVO_FMT_RGB888  = 4'b1110,
    CVO_FMT_TRGB888 = 4'b1111
  } cvo_fmt_e;
endpackage : cvo_pkg

/* src/cvo_setup_regs.sv */
`timescale 1ns/1ps
module cvo_setup_regs
  import cvo_pkg::*;
#(
  parameter logic [3:0] REV_LEVEL = 4'h1, // Arbitrary revision value
  parameter int         PAT_DEPTH = 256
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Direct register port
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // Pixel side inputs
  input  wire logic        analog_sense_i,
  input  wire logic [3:0]  zone_code_in_i,
  input  wire logic [31:0] video_serial_data_i,
  input  wire logic        chroma_match_i,
  input  wire logic [15:0] gfx_data16_i,
  input  wire logic [7:0]  cursor_pat_raddr_i,
  // Control outputs
  output logic             pixel_clock_sel_o,
  output logic             display_scan_mode_o,
  output logic [17:0]      palette_data18_o,
  output logic             cursor_enable_o,
  output logic             cursor_three_color_o,
  output logic             cursor_highlight_o,
  output logic [11:0]      cursor_x_o,
  output logic [11:0]      cursor_y_o,
  output logic [7:0]       cursor_pat_rdata_o,
  output logic             extended_palette_mode_o,
  output logic             graphics_clock_sel_o,
  output logic             graphics_clock_doubling_o,
  output logic             gamma_bypass_o,
  output logic [3:0]       video_color_format_o,
  output logic             video_fmt_valid_o,
  output logic             video_tag_o,
  output logic             video_visible_o
);

  logic [7:0]  setup_r;
  logic [7:0]  vfmt_r;
  logic [7:0]  ovl_r;
  logic [7:0]  cx_lo_r;
  logic [3:0]  cx_hi_r;
  logic [7:0]  cy_lo_r;
  logic [3:0]  cy_hi_r;
  logic [7:0]  pat_waddr_r;
  logic [7:0]  pat_raddr_r;
  logic [1:0]  color_ptr_r;
  logic        dir_r;
  logic [2:0]  sense_sync_r;
  logic        sense_r;
  logic [7:0]  pat_mem [PAT_DEPTH];
  logic [2:0]  ovl_sel;
  logic        tag_sel;
  logic        software_key_select_sel;

  // All checks below run on the register clock
  default clocking cb_asrt @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  function automatic logic hit(input logic [4:0] a, input logic [4:0] b);
    hit = (a == b);
  endfunction : hit

  function automatic logic [5:0] map5(input logic [4:0] c,
                                      input logic lsb);
    map5 = lsb ? {1'b0, c} : {c, 1'b0};
  endfunction : map5

  wire wr_pat_data = reg_wr_i && hit(reg_addr_i, CVO_ADDR_PAT_DATA);
  wire rd_pat_data = reg_rd_i && hit(reg_addr_i, CVO_ADDR_PAT_DATA);
  wire pal_access  = (reg_wr_i || reg_rd_i) &&
                     (hit(reg_addr_i, CVO_ADDR_CCOL_DATA) ||
                      hit(reg_addr_i, CVO_ADDR_GAM_DATA));
  wire wr_waddr    = reg_wr_i && (hit(reg_addr_i, CVO_ADDR_PAT_WADDR) ||
                     hit(reg_addr_i, CVO_ADDR_CCOL_WADDR) ||
                     hit(reg_addr_i, CVO_ADDR_GAM_WADDR));
  wire wr_raddr    = reg_wr_i && (hit(reg_addr_i, CVO_ADDR_PAT_RADDR) ||
                     hit(reg_addr_i, CVO_ADDR_CCOL_RADDR) ||
                     hit(reg_addr_i, CVO_ADDR_GAM_RADDR));

  // Plain control registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      setup_r <= CVO_RST_BYTE;
      vfmt_r  <= CVO_RST_BYTE;
      ovl_r   <= CVO_RST_BYTE;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, CVO_ADDR_SETUP)) begin
        setup_r <= reg_wdata_i;
      end
      if (hit(reg_addr_i, CVO_ADDR_VFMT)) begin
        vfmt_r <= reg_wdata_i;
      end
      if (hit(reg_addr_i, CVO_ADDR_OVL)) begin
        ovl_r <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cx_lo_r <= CVO_RST_BYTE;
      cx_hi_r <= CVO_RST_BYTE[3:0];
      cy_lo_r <= CVO_RST_BYTE;
      cy_hi_r <= CVO_RST_BYTE[3:0];
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, CVO_ADDR_CX_LO)) begin
        cx_lo_r <= reg_wdata_i;
      end
      if (hit(reg_addr_i, CVO_ADDR_CX_HI)) begin
        cx_hi_r <= reg_wdata_i[3:0];
      end
      if (hit(reg_addr_i, CVO_ADDR_CY_LO)) begin
        cy_lo_r <= reg_wdata_i;
      end
      if (hit(reg_addr_i, CVO_ADDR_CY_HI)) begin
        cy_hi_r <= reg_wdata_i[3:0];
      end
    end
  end

  // Address steps after each data access
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pat_waddr_r <= CVO_RST_BYTE;
      pat_raddr_r <= CVO_RST_BYTE;
    end else begin
      if (reg_wr_i && hit(reg_addr_i, CVO_ADDR_PAT_WADDR)) begin
        pat_waddr_r <= reg_wdata_i;
      end else if (wr_pat_data) begin
        pat_waddr_r <= pat_waddr_r + 8'h01;
      end
      if (reg_wr_i && hit(reg_addr_i, CVO_ADDR_PAT_RADDR)) begin
        pat_raddr_r <= reg_wdata_i;
      end else if (rd_pat_data) begin
        pat_raddr_r <= pat_raddr_r + 8'h01;
      end
    end
  end

  // One flat array of PAT_DEPTH bytes, no reset
  always_ff @(posedge clk_i) begin
    if (wr_pat_data) begin
      pat_mem[pat_waddr_r] <= reg_wdata_i;
    end
    cursor_pat_rdata_o <= pat_mem[cursor_pat_raddr_i];
  end

  // Status reads do not advance it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      color_ptr_r <= CVO_PTR_RED;
    end else if (wr_waddr || wr_raddr) begin
      color_ptr_r <= CVO_PTR_RED;
    end else if (pal_access) begin
      color_ptr_r <= (color_ptr_r == CVO_PTR_BLUE) ? CVO_PTR_RED
                                                   : color_ptr_r + 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_r <= 1'b0;
    end else if (wr_raddr) begin
      dir_r <= 1'b1;
    end else if (wr_waddr) begin
      dir_r <= 1'b0;
    end
  end

  // Pin synchronised; accept once stages agree
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sense_sync_r <= 3'h0;
      sense_r      <= 1'b0;
    end else begin
      sense_sync_r <= {sense_sync_r[1:0], analog_sense_i};
      if (sense_sync_r[1] == sense_sync_r[2]) begin
        sense_r <= sense_sync_r[2];
      end
    end
  end

  // Read data; unmapped addresses answer zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o  <= CVO_RST_BYTE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          CVO_ADDR_PAT_WADDR: reg_rdata_o <= pat_waddr_r;
          CVO_ADDR_PAT_RADDR: reg_rdata_o <= pat_raddr_r;
          CVO_ADDR_SETUP:     reg_rdata_o <= setup_r;
          CVO_ADDR_STATUS:
            reg_rdata_o <= {REV_LEVEL, sense_r, dir_r, color_ptr_r};
          CVO_ADDR_PAT_DATA:  reg_rdata_o <= pat_mem[pat_raddr_r];
          CVO_ADDR_CX_LO:     reg_rdata_o <= cx_lo_r;
          CVO_ADDR_CX_HI:     reg_rdata_o <= {4'h0, cx_hi_r};
          CVO_ADDR_CY_LO:     reg_rdata_o <= cy_lo_r;
          CVO_ADDR_CY_HI:     reg_rdata_o <= {4'h0, cy_hi_r};
          CVO_ADDR_VFMT:      reg_rdata_o <= vfmt_r;
          CVO_ADDR_OVL:       reg_rdata_o <= ovl_r;
          default:            reg_rdata_o <= CVO_RST_BYTE;
        endcase
      end
    end
  end

  // Select only; the clock mux sits in the pad ring
  assign pixel_clock_sel_o         = setup_r[CVO_SETUP_CLKSEL];
  assign display_scan_mode_o       = setup_r[CVO_SETUP_SCAN];
  assign extended_palette_mode_o   = vfmt_r[CVO_VFMT_EXTPAL];
  // Load clock or selected pixel clock
  assign graphics_clock_sel_o      = vfmt_r[CVO_VFMT_GCLKSEL];
  assign graphics_clock_doubling_o = vfmt_r[CVO_VFMT_DOUBLE];
  assign gamma_bypass_o            = vfmt_r[CVO_VFMT_GAMMA_BYPASS];
  assign video_color_format_o      = vfmt_r[3:0];
  assign cursor_x_o                = {cx_hi_r, cx_lo_r};
  assign cursor_y_o                = {cy_hi_r, cy_lo_r};

  always_comb begin
    cursor_enable_o      = 1'b1;
    cursor_three_color_o = 1'b0;
    cursor_highlight_o   = 1'b0;
    case (cvo_cursor_e'(setup_r[1:0]))
      CVO_CUR_OFF:    cursor_enable_o      = 1'b0;
      CVO_CUR_THREE:  cursor_three_color_o = 1'b1;
      CVO_CUR_HILITE: cursor_highlight_o   = 1'b1;
      CVO_CUR_TWO:    cursor_highlight_o   = 1'b0;
      default:        cursor_enable_o      = 1'b0;
    endcase
  end

  always_comb begin
    video_fmt_valid_o = 1'b1;
    tag_sel           = 1'b0;
    case (cvo_fmt_e'(vfmt_r[3:0]))
      CVO_FMT_YUV:     tag_sel = 1'b0;
      CVO_FMT_YUV_TAG: tag_sel = video_serial_data_i[CVO_VSD_TAG_UV];
      CVO_FMT_RGB565:  tag_sel = 1'b0;
      CVO_FMT_RGB555:  tag_sel = 1'b0;
      CVO_FMT_TRGB555: tag_sel = video_serial_data_i[CVO_VSD_TAG_MSB5];
      CVO_FMT_RGB888:  tag_sel = 1'b0;
      CVO_FMT_TRGB888: tag_sel = video_serial_data_i[CVO_VSD_TAG_MSB8];
      default:         video_fmt_valid_o = 1'b0;
    endcase
  end

  assign software_key_select_sel = (zone_code_in_i == CVO_ZONE_SOFTWARE_KEY_SELECT);
  // Select order is key, tag, colour
  assign ovl_sel   = {software_key_select_sel, tag_sel, chroma_match_i};

  // High shows video, low shows graphics
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      video_visible_o <= 1'b0;
      video_tag_o     <= 1'b0;
    end else begin
      video_visible_o <= ovl_r[ovl_sel];
      video_tag_o     <= tag_sel;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      palette_data18_o <= 18'h0;
    end else begin
      palette_data18_o <= {map5(gfx_data16_i[15:11], setup_r[CVO_SETUP_PMAP]),
                           gfx_data16_i[10:5],
                           map5(gfx_data16_i[4:0], setup_r[CVO_SETUP_PMAP])};
    end
  end

  // Settle count for the sense check; reads synchronised stages only
  logic [2:0] sense_cnt_r;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sense_cnt_r <= 3'h0;
    end else if (sense_sync_r[1] != sense_sync_r[2]) begin
      sense_cnt_r <= 3'h0;
    end else if (sense_cnt_r != 3'h7) begin
      sense_cnt_r <= sense_cnt_r + 3'h1;
    end
  end

  AST_PTR_RANGE: assert property (
    color_ptr_r != 2'h3)
    else $error("colour pointer left its three values");

  AST_PAT_WINC: assert property (
    wr_pat_data |=> pat_waddr_r == $past(pat_waddr_r) + 8'h01)
    else $error("pattern write address did not step");

  AST_PAT_RINC: assert property (
    rd_pat_data |=> pat_raddr_r == $past(pat_raddr_r) + 8'h01)
    else $error("pattern read address did not step");

  AST_DIR_READ: assert property (
    wr_raddr ##1 (!wr_waddr && !wr_raddr) [*2] |-> dir_r)
    else $error("direction bit lost after read address write");

  AST_XHI_ZERO: assert property (
    reg_rd_i && hit(reg_addr_i, CVO_ADDR_CX_HI) |=>
      reg_rvalid_o && reg_rdata_o[7:4] == 4'h0)
    else $error("reserved X bits read non-zero");

  AST_OVL_SEL: assert property (
    1'b1 |=> video_visible_o ==
      $past(ovl_r[{zone_code_in_i == CVO_ZONE_SOFTWARE_KEY_SELECT, tag_sel,
                   chroma_match_i}]))
    else $error("transparency not taken from selected opcode bit");

  AST_SOFTWARE_KEY_SELECT: assert property (
    zone_code_in_i == CVO_ZONE_SOFTWARE_KEY_SELECT && !tag_sel && !chroma_match_i |=>
      video_visible_o == $past(ovl_r[4]))
    else $error("software key did not pick opcode bit 4");

  AST_SENSE: assert property (
    sense_cnt_r >= 3'h2 |-> sense_r == sense_sync_r[2])
    else $error("sense bit differs from settled input");

  AST_CUR_OFF: assert property (
    setup_r[1:0] == 2'b00 |-> !cursor_enable_o)
    else $error("cursor enabled in disabled mode");

  AST_STAT_RD: assert property (
    reg_rd_i && hit(reg_addr_i, CVO_ADDR_STATUS) |=>
      $stable(color_ptr_r) && $stable(pat_raddr_r))
    else $error("status read changed pointers");

  AST_REV: assert property (
    reg_rd_i && hit(reg_addr_i, CVO_ADDR_STATUS) |=>
      reg_rdata_o[7:4] == REV_LEVEL)
    else $error("revision nibble wrong");

  COV_PAL_WRAP: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    color_ptr_r == CVO_PTR_BLUE ##1 color_ptr_r == CVO_PTR_RED);
  COV_PAT_BURST: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_pat_data ##1 wr_pat_data ##1 wr_pat_data);
  COV_VIDEO_SHOWN: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    ovl_sel == 3'b111 ##1 video_visible_o);
  COV_SENSE_UP: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    !sense_r ##1 sense_r);

endmodule : cvo_setup_regs

/* verif/cvo_host_model.sv */
`timescale 1ns/1ps
module cvo_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [4:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o
);
  logic [7:0] exp_q[$];

  initial begin
    reg_addr_o  = 5'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end

  // Bank via offset
  // Bank index lives outside this port, so the direct offset stands for it
  // Host byte writes
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b1;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = ~reg_wdata_o;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b1;
    exp_q.push_back(e);
  endtask : rd

  // Released lines toggle so stale data is never mistaken for valid
  task automatic idle();
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask : idle
endmodule : cvo_host_model

/* verif/tb_cursor_video_overlay_setup_regs.sv */
`timescale 1ns/1ps
module tb_cursor_video_overlay_setup_regs;
  import cvo_pkg::*;
  localparam logic [3:0] CHIP_VERSION_FIELD = 4'h1; // Arbitrary revision value

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [4:0]  reg_addr_i;
  logic        reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0]  reg_wdata_i, reg_rdata_o, cursor_pat_raddr_i;
  logic        analog_sense_i, chroma_match_i;
  logic [3:0]  zone_code_in_i, video_color_format_o, vf_hi;
  logic [31:0] video_serial_data_i, seed;
  logic [15:0] gfx_data16_i;
  logic        pixel_clock_sel_o, display_scan_mode_o, cursor_enable_o;
  logic        cursor_three_color_o, cursor_highlight_o;
  logic [17:0] palette_data18_o, pal;
  logic [11:0] cursor_x_o, cursor_y_o;
  logic [7:0]  cursor_pat_rdata_o, v, op;
  logic [7:0]  pd [3];
  logic        extended_palette_mode_o, graphics_clock_sel_o;
  logic        graphics_clock_doubling_o, gamma_bypass_o;
  logic        video_fmt_valid_o, video_tag_o, video_visible_o;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  assign vf_hi = {extended_palette_mode_o, graphics_clock_sel_o,
                  graphics_clock_doubling_o, gamma_bypass_o};

  always #5 clk_i = ~clk_i;

  cvo_host_model u_host (.clk_i, .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

  cvo_setup_regs #(.REV_LEVEL(CHIP_VERSION_FIELD), .PAT_DEPTH(256)) u_dut (.clk_i,
    .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .analog_sense_i, .zone_code_in_i,
    .video_serial_data_i, .chroma_match_i, .gfx_data16_i,
    .cursor_pat_raddr_i, .pixel_clock_sel_o, .display_scan_mode_o,
    .palette_data18_o, .cursor_enable_o, .cursor_three_color_o,
    .cursor_highlight_o, .cursor_x_o, .cursor_y_o, .cursor_pat_rdata_o,
    .extended_palette_mode_o, .graphics_clock_sel_o,
    .graphics_clock_doubling_o, .gamma_bypass_o, .video_color_format_o,
    .video_fmt_valid_o, .video_tag_o, .video_visible_o);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [7:0] st(input logic s, input logic d,
                                    input logic [1:0] p);
    return {CHIP_VERSION_FIELD, s, d, p};
  endfunction : st

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // Read answers are matched oldest first against the host's notes
  always @(negedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (u_host.exp_q.size() == 0)
        chk("unexpected read", 32'h1, 32'h0);
      else
        chk("read data", 32'(reg_rdata_o),
            32'(u_host.exp_q.pop_front()));
    end
  end

  initial begin
    #50us;
    n_mismatch++;
    results();
  end

  initial begin
    seed = 32'hfc4a3277;
    analog_sense_i = 1'b0;
    chroma_match_i = 1'b0;
    zone_code_in_i = 4'h0;
    video_serial_data_i = 32'h0;
    gfx_data16_i = 16'h0;
    cursor_pat_raddr_i = 8'h00;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk("cursor x reset", 32'(cursor_x_o), 32'h0);
    chk("cursor y reset", 32'(cursor_y_o), 32'h0);
    for (int a = 12; a <= 17; a++) u_host.rd(5'(a), 8'h00);
    u_host.rd(CVO_ADDR_STATUS, st(1'b0, 1'b0, 2'h0));
    u_host.rd(5'h1f, 8'h00);
    u_host.idle();
    for (int m = 0; m < 4; m++) begin
      seed = lfsr_next(seed);
      gfx_data16_i = seed[31:16];
      v = {3'h0, seed[20:19], m[0], m[1:0]};
      u_host.wr(CVO_ADDR_SETUP, v);
      u_host.idle();
      @(negedge clk_i);
      pal = v[2] ? {1'b0, seed[31:27], seed[26:21], 1'b0, seed[20:16]}
                 : {seed[31:27], 1'b0, seed[26:21], seed[20:16], 1'b0};
      chk("clock select", 32'(pixel_clock_sel_o), 32'(v[4]));
      chk("scan mode", 32'(display_scan_mode_o), 32'(v[3]));
      chk("palette map", 32'(palette_data18_o), 32'(pal));
      chk("cursor on", 32'(cursor_enable_o), 32'(m != 0));
      chk("three colour", 32'(cursor_three_color_o), 32'(m == 1));
      chk("highlight", 32'(cursor_highlight_o), 32'(m == 2));
    end
    seed = lfsr_next(seed);
    u_host.wr(CVO_ADDR_CX_LO, 8'h20);
    u_host.wr(CVO_ADDR_CX_HI, seed[7:0]);
    u_host.wr(CVO_ADDR_CY_LO, 8'h20);
    u_host.wr(CVO_ADDR_CY_HI, 8'h00);
    u_host.rd(CVO_ADDR_CX_HI, {4'h0, seed[3:0]});
    u_host.rd(CVO_ADDR_CY_LO, 8'h20);
    u_host.idle();
    chk("cursor x", 32'(cursor_x_o), {20'h0, seed[3:0], 8'h20});
    chk("cursor y", 32'(cursor_y_o), 32'h020);
    for (int c = 0; c < 16; c++) begin
      seed = lfsr_next(seed);
      v = {seed[7:4], 4'(c)};
      u_host.wr(CVO_ADDR_VFMT, v);
      u_host.rd(CVO_ADDR_VFMT, v);
      u_host.idle();
      chk("format flags", 32'(vf_hi), 32'(v[7:4]));
      chk("format code", 32'(video_color_format_o), 32'(c));
      chk("format valid", 32'(video_fmt_valid_o),
          32'(c inside {0, 1, 8, 10, 11, 14, 15}));
    end
    seed = lfsr_next(seed);
    u_host.wr(CVO_ADDR_PAT_WADDR, 8'hfe);
    for (int i = 0; i < 3; i++) begin
      pd[i] = seed[8*i+8 +: 8];
      u_host.wr(CVO_ADDR_PAT_DATA, pd[i]);
    end
    u_host.wr(CVO_ADDR_PAT_RADDR, 8'hfe);
    for (int i = 0; i < 3; i++) u_host.rd(CVO_ADDR_PAT_DATA, pd[i]);
    u_host.rd(CVO_ADDR_PAT_RADDR, 8'h01);
    u_host.rd(CVO_ADDR_PAT_WADDR, 8'h01);
    u_host.idle();
    cursor_pat_raddr_i = 8'h00;
    repeat (2) @(negedge clk_i);
    chk("pattern display", 32'(cursor_pat_rdata_o), 32'(pd[2]));
    u_host.wr(CVO_ADDR_CCOL_WADDR, 8'h00);
    u_host.rd(CVO_ADDR_STATUS, st(1'b0, 1'b0, 2'h0));
    for (int k = 1; k <= 3; k++) begin
      u_host.wr(CVO_ADDR_CCOL_DATA, 8'h5a);
      u_host.rd(CVO_ADDR_STATUS, st(1'b0, 1'b0, 2'(k % 3)));
      u_host.rd(CVO_ADDR_STATUS, st(1'b0, 1'b0, 2'(k % 3)));
    end
    u_host.wr(CVO_ADDR_CCOL_RADDR, 8'h00);
    u_host.wr(CVO_ADDR_STATUS, 8'hff);
    u_host.rd(CVO_ADDR_STATUS, st(1'b0, 1'b1, 2'h0));
    u_host.idle();
    analog_sense_i = 1'b1;
    repeat (8) @(negedge clk_i);
    u_host.rd(CVO_ADDR_STATUS, st(1'b1, 1'b1, 2'h0));
    u_host.idle();
    analog_sense_i = 1'b0;
    repeat (8) @(negedge clk_i);
    u_host.rd(CVO_ADDR_STATUS, st(1'b0, 1'b1, 2'h0));
    seed = lfsr_next(seed);
    op = seed[7:0];
    u_host.wr(CVO_ADDR_VFMT, {4'h0, CVO_FMT_TRGB888});
    u_host.wr(CVO_ADDR_OVL, op);
    u_host.rd(CVO_ADDR_OVL, op);
    u_host.idle();
    for (int s = 0; s < 8; s++) begin
      seed = lfsr_next(seed);
      zone_code_in_i = s[2] ? CVO_ZONE_SOFTWARE_KEY_SELECT : 4'hd;
      video_serial_data_i = {s[1], seed[30:0]};
      chroma_match_i = s[0];
      repeat (3) @(negedge clk_i);
      chk("tag", 32'(video_tag_o), 32'(s[1]));
      chk("visible", 32'(video_visible_o), 32'(op[s]));
    end
    repeat (3) @(negedge clk_i);
    chk("reads pending", 32'(u_host.exp_q.size()), 32'h0);
    results();
  end
endmodule : tb_cursor_video_overlay_setup_regs
